// ===== rtl/ptra_target.sv
module ptra_target
  import ptra_pkg::*;
(
  input  logic            clk_sys,          // System clock
  input  logic            reset,            // Synchronous reset, high
  input  logic [3:0]      avs_address,      // Register byte address
  input  logic            avs_read,         // Read request
  input  logic            avs_write,        // Write request
  input  logic [31:0]     avs_writedata,    // Write data
  input  logic [3:0]      avs_byteenable,   // Byte enables
  output logic [31:0]     avs_readdata,     // Read data
  output logic            avs_waitrequest,  // Stall
  input  ptra_lnk_s       lnk_in,           // Link request, foreign domain
  output logic            lnk_rsp_valid,    // Answer present
  output ptra_rsp_e       lnk_rsp,          // Answer kind
  output logic [DW-1:0]   lnk_rdata,        // Read data
  output logic            app_valid,        // Memory access request
  output ptra_rgn_e       app_rgn,          // Target region
  output logic            app_we,           // Write access
  output logic [AW-1:0]   app_addr,         // Access address
  output logic [DW-1:0]   app_wdata,        // Write data
  input  logic [4:0]      app_free,         // Per region slot free
  input  logic            app_rvalid,       // Read data valid
  input  logic [DW-1:0]   app_rdata         // Read data
);

  typedef struct packed {
    ptra_lnk_s                s1;
    ptra_lnk_s                s2;
    logic                     clk_d;
    ptra_st_e                 st;
    ptra_lnk_s                cur;
    logic                     rsp_valid;
    ptra_rsp_e                rsp;
    logic [DW-1:0]            rdata;
    logic [NQ-1:0]            pw_valid;
    logic [NQ-1:0][AW-1:0]    pw_addr;
    logic [NQ-1:0][DW-1:0]    pw_data;
    logic [NQ-1:0]            dr_valid;
    logic [NQ-1:0]            dr_done;
    logic [NQ-1:0][AW-1:0]    dr_addr;
    logic [NQ-1:0][DW-1:0]    dr_data;
    logic [NQ-1:0]            err;
    logic [7:0]               mb_wait;
    logic [7:0]               ws_cnt;
    logic [1:0]               bq;
    logic                     app_valid;
    ptra_rgn_e                app_rgn;
    logic                     app_we;
    logic [AW-1:0]            app_addr;
    logic [DW-1:0]            app_wdata;
    logic                     av_ack;
    logic [31:0]              av_rdata;
  } ptra_state_s;

  ptra_state_s   r_reg;
  ptra_state_s   r_next;
  logic          take;
  logic          t_rd;
  ptra_rgn_e     t_rg;
  logic [1:0]    t_q;
  logic          t_nb;
  logic          bg_any;
  logic [1:0]    bg_q;
  logic [NQ-1:0] set_err;
  logic [NQ-1:0] clr_err;

  function automatic ptra_state_s answer(input ptra_state_s s, input ptra_rsp_e c, input logic [DW-1:0] d);
    answer           = s;
    answer.rsp       = c;
    answer.rsp_valid = 1'b1;
    answer.rdata     = d;
    answer.st        = ST_IDLE;
    answer.app_valid = 1'b0;
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    r_next      = r_reg;
    r_next.s1   = lnk_in;
    r_next.s2   = r_reg.s1;
    r_next.clk_d = r_reg.s2.clk;
    set_err     = '0;
    clr_err     = '0;
    take        = 1'b0;
    t_rd        = ~r_reg.s2.wr;
    t_rg        = ptra_region_of(r_reg.s2.addr); // [R25]
    t_q         = (t_rg == RGN_DM) ? Q_DM : ((t_rg == RGN_VC) ? Q_VC : Q_MB);
    t_nb        = r_reg.s2.burst;
    bg_any      = 1'b0;
    bg_q        = Q_DM;
    // Only a granted region is started; link phases still wait while a background access runs
    for (int i = NQ - 1; i >= 0; i--) begin
      if ((r_reg.pw_valid[i] | (r_reg.dr_valid[i] & ~r_reg.dr_done[i])) & app_free[ptra_q_rgn(2'(i))]) begin // [R8]
        bg_any = 1'b1;
        bg_q   = 2'(i);
      end
    end

    // Register bus, one wait cycle per access
    r_next.av_ack = 1'b0;
    if ((avs_read | avs_write) & ~r_reg.av_ack) begin
      r_next.av_ack   = 1'b1;
      r_next.av_rdata = 32'h00000000;
      if (avs_read) begin
        case (avs_address)
          AV_PEND:   r_next.av_rdata = {29'h0, r_reg.pw_valid}; // [R11] [R18] [R22]
          AV_ERR:    r_next.av_rdata = {29'h0, r_reg.err};
          AV_MBWAIT: r_next.av_rdata = {24'h0, r_reg.mb_wait};
          default:   r_next.av_rdata = 32'h00000000;
        endcase
      end
    end
    // Writes land at the edge that completes the transfer
    if (avs_write & r_reg.av_ack & avs_byteenable[0]) begin
      case (avs_address)
        AV_ERR:    clr_err = avs_writedata[2:0];
        AV_MBWAIT: r_next.mb_wait = avs_writedata[7:0];
        default:   ;
      endcase
    end

    // Answer withdrawn once the initiator drops its request
    if (r_reg.s2.clk & ~r_reg.clk_d & ~r_reg.s2.req) begin
      r_next.rsp_valid = 1'b0;
    end

    case (r_reg.st)
      ST_IDLE: begin
        if (r_reg.s2.clk & ~r_reg.clk_d & r_reg.s2.req & ~r_reg.rsp_valid) begin
          take       = 1'b1;
          r_next.cur = r_reg.s2;
          if (r_reg.s2.par_err) begin
            r_next = answer(r_next, t_rd ? RSP_ABORT : RSP_DONE, '0); // [R3] [R4]
          end else begin
            case (t_rg)
              RGN_REG, RGN_CM: begin
                if (t_rg == RGN_REG && t_rd && r_reg.s2.addr >= REG_TOP) begin
                  r_next = answer(r_next, RSP_DONE, '0); // [R2]
                end else begin
                  r_next.st        = ST_FG; // [R1] [R6]
                  r_next.app_valid = 1'b1;
                  r_next.app_rgn   = t_rg;
                  r_next.app_we    = r_reg.s2.wr;
                  r_next.app_addr  = r_reg.s2.addr;
                  r_next.app_wdata = r_reg.s2.wdata;
                end
              end
              RGN_DM, RGN_VC, RGN_MB: begin
                if (r_reg.s2.wr) begin
                  if (r_reg.dr_valid[t_q] | r_reg.pw_valid[t_q]) begin
                    set_err[t_q] = 1'b1; // [R12] [R16] [R19] [R23]
                    if (t_q != Q_MB) begin
                      r_next.dr_valid[t_q] = 1'b0;
                      r_next.pw_valid[t_q] = 1'b0;
                    end
                    r_next = answer(r_next, t_nb ? RSP_DISC : RSP_DONE, '0); // [R24]
                  end else if (t_q != Q_MB && app_free[t_rg]) begin
                    r_next.st        = ST_FG; // [R10] [R17]
                    r_next.app_valid = 1'b1;
                    r_next.app_rgn   = t_rg;
                    r_next.app_we    = 1'b1;
                    r_next.app_addr  = r_reg.s2.addr;
                    r_next.app_wdata = r_reg.s2.wdata;
                  end else begin
                    r_next.pw_valid[t_q] = 1'b1; // [R10] [R17] [R21]
                    r_next.pw_addr[t_q]  = r_reg.s2.addr;
                    r_next.pw_data[t_q]  = r_reg.s2.wdata;
                    r_next = answer(r_next, t_nb ? RSP_DISC : RSP_DONE, '0); // [R9] [R24]
                  end
                end else begin
                  if (r_reg.pw_valid[t_q]) begin
                    r_next = answer(r_next, RSP_RETRY, '0); // [R13] [R20]
                  end else if (r_reg.dr_valid[t_q]) begin
                    if (r_reg.dr_done[t_q] && r_reg.dr_addr[t_q] == r_reg.s2.addr) begin
                      r_next.dr_valid[t_q] = 1'b0; // [R15]
                      r_next = answer(r_next, t_nb ? RSP_DISC : RSP_DONE, r_reg.dr_data[t_q]);
                    end else begin
                      r_next = answer(r_next, RSP_RETRY, '0); // [R15] [R20]
                    end
                  end else if (t_q != Q_MB && app_free[t_rg]) begin
                    r_next.st        = ST_FG; // [R8] [R10]
                    r_next.app_valid = 1'b1;
                    r_next.app_rgn   = t_rg;
                    r_next.app_we    = 1'b0;
                    r_next.app_addr  = r_reg.s2.addr;
                  end else begin
                    r_next.dr_valid[t_q] = 1'b1; // [R14] [R20] [R21]
                    r_next.dr_done[t_q]  = 1'b0;
                    r_next.dr_addr[t_q]  = r_reg.s2.addr;
                    r_next = answer(r_next, RSP_RETRY, '0);
                  end
                end
              end
              default: r_next = answer(r_next, RSP_DONE, '0);
            endcase
          end
        end else if (bg_any) begin
          if (bg_q == Q_MB && r_reg.ws_cnt < r_reg.mb_wait) begin
            r_next.ws_cnt = r_reg.ws_cnt + 8'h01; // [R21]
          end else begin
            r_next.ws_cnt    = 8'h00;
            r_next.st        = ST_BG;
            r_next.bq        = bg_q;
            r_next.app_valid = 1'b1;
            r_next.app_rgn   = ptra_q_rgn(bg_q);
            r_next.app_we    = r_reg.pw_valid[bg_q];
            r_next.app_addr  = r_reg.pw_valid[bg_q] ? r_reg.pw_addr[bg_q] : r_reg.dr_addr[bg_q];
            r_next.app_wdata = r_reg.pw_data[bg_q];
          end
        end
      end
      ST_FG: begin
        if (r_reg.app_rgn == RGN_REG || app_free[r_reg.app_rgn]) begin // [R5] [R7]
          if (r_reg.app_we) begin
            r_next = answer(r_next, (r_reg.app_rgn >= RGN_DM && r_reg.cur.burst) ? RSP_DISC : RSP_DONE, '0);
          end else begin
            r_next.app_valid = 1'b0;
            r_next.st        = ST_FG_RD;
          end
        end
      end
      ST_FG_RD: begin
        if (app_rvalid) begin
          r_next = answer(r_next, (r_reg.app_rgn >= RGN_DM && r_reg.cur.burst) ? RSP_DISC : RSP_DONE,
                          app_rdata); // [R24]
        end
      end
      ST_BG: begin
        if (app_free[r_reg.app_rgn]) begin // [R8]
          r_next.app_valid = 1'b0;
          if (r_reg.app_we) begin
            r_next.pw_valid[r_reg.bq] = 1'b0;
            r_next.st                 = ST_IDLE;
          end else begin
            r_next.st = ST_BG_RD;
          end
        end
      end
      ST_BG_RD: begin
        if (app_rvalid) begin
          r_next.dr_data[r_reg.bq] = app_rdata;
          r_next.dr_done[r_reg.bq] = 1'b1;
          r_next.st                = ST_IDLE;
        end
      end
      default: r_next.st = ST_IDLE;
    endcase

    // Hardware set wins over software clear
    r_next.err = (r_reg.err & ~clr_err) | set_err;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      r_reg         <= '0;
      r_reg.mb_wait <= MBWAIT_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign avs_readdata    = r_reg.av_rdata;
  assign avs_waitrequest = (avs_read | avs_write) & ~r_reg.av_ack;
  assign lnk_rsp_valid   = r_reg.rsp_valid;
  assign lnk_rsp         = r_reg.rsp;
  assign lnk_rdata       = r_reg.rdata;
  assign app_valid       = r_reg.app_valid;
  assign app_rgn         = r_reg.app_rgn;
  assign app_we          = r_reg.app_we;
  assign app_addr        = r_reg.app_addr;
  assign app_wdata       = r_reg.app_wdata;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_abort_perr_read: assert property (@(posedge clk_sys) disable iff (reset) // [R3]
    take && r_reg.s2.par_err && t_rd |=> lnk_rsp_valid && lnk_rsp == RSP_ABORT)
    else $error("parity read not aborted");
  a_perr_write_drop: assert property (@(posedge clk_sys) disable iff (reset) // [R4]
    take && r_reg.s2.par_err && !t_rd |=> lnk_rsp == RSP_DONE && r_reg.pw_valid == $past(r_reg.pw_valid)
    && !app_valid)
    else $error("parity write not discarded");
  a_reg_write_fast: assert property (@(posedge clk_sys) disable iff (reset) // [R5]
    take && !r_reg.s2.par_err && t_rg == RGN_REG && !t_rd |-> ##2 lnk_rsp_valid && lnk_rsp == RSP_DONE)
    else $error("register write stalled");
  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (reset) // [R2]
    take && !r_reg.s2.par_err && t_rg == RGN_REG && t_rd && r_reg.s2.addr >= REG_TOP
    |=> lnk_rsp_valid && lnk_rdata == 32'h00000000)
    else $error("reserved read not zero");
  a_cm_stall_full: assert property (@(posedge clk_sys) disable iff (reset) // [R7]
    r_reg.st == ST_FG && r_reg.app_rgn == RGN_CM && !app_free[RGN_CM] |=> !lnk_rsp_valid)
    else $error("answer while memory full");
  a_dm_double_post: assert property (@(posedge clk_sys) disable iff (reset) // [R12]
    take && !r_reg.s2.par_err && t_rg == RGN_DM && !t_rd && r_reg.pw_valid[Q_DM]
    |=> r_reg.err[Q_DM] && !r_reg.pw_valid[Q_DM])
    else $error("double post not dropped");
  a_dm_retry_post: assert property (@(posedge clk_sys) disable iff (reset) // [R13]
    take && !r_reg.s2.par_err && t_rg == RGN_DM && t_rd && r_reg.pw_valid[Q_DM] |=> lnk_rsp == RSP_RETRY)
    else $error("read not retried");
  a_delay_latch: assert property (@(posedge clk_sys) disable iff (reset) // [R14]
    take && !r_reg.s2.par_err && t_rg == RGN_DM && t_rd && !r_reg.pw_valid[Q_DM] && !r_reg.dr_valid[Q_DM]
    && !app_free[RGN_DM] |=> r_reg.dr_valid[Q_DM] && r_reg.dr_addr[Q_DM] == $past(r_reg.s2.addr)
    && lnk_rsp == RSP_RETRY)
    else $error("delayed read not latched");
  a_vc_cancel: assert property (@(posedge clk_sys) disable iff (reset) // [R16]
    take && !r_reg.s2.par_err && t_rg == RGN_VC && !t_rd && r_reg.dr_valid[Q_VC]
    |=> !r_reg.dr_valid[Q_VC] && r_reg.err[Q_VC])
    else $error("channel write did not cancel");
  a_mb_keep_queue: assert property (@(posedge clk_sys) disable iff (reset) // [R23]
    take && !r_reg.s2.par_err && t_rg == RGN_MB && !t_rd && r_reg.pw_valid[Q_MB]
    |=> r_reg.err[Q_MB] && r_reg.pw_valid[Q_MB] && r_reg.pw_addr[Q_MB] == $past(r_reg.pw_addr[Q_MB]))
    else $error("minibridge queue lost");
  a_mb_post: assert property (@(posedge clk_sys) disable iff (reset) // [R21]
    take && !r_reg.s2.par_err && t_rg == RGN_MB && !t_rd && !r_reg.pw_valid[Q_MB] && !r_reg.dr_valid[Q_MB]
    |=> r_reg.pw_valid[Q_MB] && !app_valid)
    else $error("minibridge write not posted");
  a_burst_disc: assert property (@(posedge clk_sys) disable iff (reset) // [R24]
    $rose(lnk_rsp_valid) && r_reg.cur.burst && !r_reg.cur.par_err
    && ptra_region_of(r_reg.cur.addr) inside {RGN_DM, RGN_VC, RGN_MB} |-> lnk_rsp inside {RSP_RETRY, RSP_DISC})
    else $error("burst not disconnected");

endmodule

// ===== rtl/ptra_pkg.sv
// How it works
// [R1] Register space served at once without arbitration; bursts allowed both ways.
// [R2] Reads of reserved register-space locations return zero.
// [R3] Address parity error on a read ends it with target abort.
// [R4] Address parity error on a write: accepted at the link, then discarded.
// [R5] Register-space bursts never stall; target ready on every data phase.
// [R6] Connection memory has dedicated slots; read and write bursts allowed.
// [R7] Connection memory FIFO full holds target ready low until it drains.
// [R8] Data and channel memory serve switching first; target access lowest priority.
// [R9] No bursts to data memory; single data phase only.
// [R10] Data memory: direct access if free, else post write or delay read.
// [R11] One posted data-memory write at most, flagged in pending bit 0.
// [R12] Second data-memory write while one queued drops both, sets error bit 0.
// [R13] Data-memory read while a write is queued gets a retry.
// [R14] One delayed data-memory read; latch address and command, answer retry.
// [R15] Retry all reads until delayed read done; identical repeat then completes.
// [R16] Write during pending delayed read cancels both and sets region error bit.
// [R17] No bursts to channel memory; direct if free, else post or delay.
// [R18] One posted channel-memory write at most, flagged in pending bit 1.
// [R19] Second channel-memory write while queued drops both, sets error bit 1.
// [R20] Channel memory: retry reads during queued write; one delayed read, retried.
// [R21] Minibridge: no bursts; writes always posted, reads always delayed, wait-state paced.
// [R22] Queued minibridge write flagged in pending bit 2; later write ignored.
// [R23] Rejected minibridge write sets error bit 2; earlier operation still completes.
// [R24] Burst into a no-burst region: first phase completes, then disconnect.
// [R25] Each address decodes to one region; requests cross from the link clock.
package ptra_pkg;

  localparam int          AW          = 20;
  localparam int          DW          = 32;
  localparam int          NQ          = 3;
  localparam logic [1:0]  Q_DM        = 2'h0;
  localparam logic [1:0]  Q_VC        = 2'h1;
  localparam logic [1:0]  Q_MB        = 2'h2;
  localparam logic [3:0]  SEL_REG     = 4'h0;
  localparam logic [3:0]  SEL_CM      = 4'h1;
  localparam logic [3:0]  SEL_DM      = 4'h2;
  localparam logic [3:0]  SEL_VC      = 4'h3;
  localparam logic [3:0]  SEL_MB      = 4'h4;
  localparam logic [19:0] REG_TOP     = 20'h00800;
  localparam logic [3:0]  AV_PEND     = 4'h0;
  localparam logic [3:0]  AV_ERR      = 4'h4;
  localparam logic [3:0]  AV_MBWAIT   = 4'h8;
  localparam logic [7:0]  MBWAIT_RST  = 8'h04;

  typedef enum logic [2:0] {RGN_REG, RGN_CM, RGN_DM, RGN_VC, RGN_MB, RGN_NONE} ptra_rgn_e;
  typedef enum logic [1:0] {RSP_DONE, RSP_RETRY, RSP_ABORT, RSP_DISC} ptra_rsp_e;
  typedef enum logic [2:0] {ST_IDLE, ST_FG, ST_FG_RD, ST_BG, ST_BG_RD} ptra_st_e;

  typedef struct packed {
    logic          clk;
    logic          req;
    logic          wr;
    logic          burst;
    logic          par_err;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } ptra_lnk_s;

  function automatic ptra_rgn_e ptra_region_of(input logic [AW-1:0] a);
    case (a[19:16])
      SEL_REG: ptra_region_of = RGN_REG;
      SEL_CM:  ptra_region_of = RGN_CM;
      SEL_DM:  ptra_region_of = RGN_DM;
      SEL_VC:  ptra_region_of = RGN_VC;
      SEL_MB:  ptra_region_of = RGN_MB;
      default: ptra_region_of = RGN_NONE;
    endcase
  endfunction

  function automatic ptra_rgn_e ptra_q_rgn(input logic [1:0] q);
    case (q)
      Q_DM:    ptra_q_rgn = RGN_DM;
      Q_VC:    ptra_q_rgn = RGN_VC;
      default: ptra_q_rgn = RGN_MB;
    endcase
  endfunction

endpackage

// ===== testbench/ptra_ini_model.sv
module ptra_ini_model
  import ptra_pkg::*;
(
  output ptra_lnk_s     lnk,        // Link request
  input  logic          rsp_valid,  // Answer present
  input  ptra_rsp_e     rsp,        // Answer kind
  input  logic [DW-1:0] rdata       // Read data
);
  timeunit 1ns;
  timeprecision 1ns;

  initial lnk = '0;

  // **********
  // One data phase; link clock runs only here
  // **********
  task automatic phase(input logic wr, input logic bst, input logic pe, input logic [AW-1:0] a,
                       input logic [DW-1:0] d, output ptra_rsp_e r, output logic [DW-1:0] q);
    int n;
    #37;
    lnk = '{clk: 1'b0, req: 1'b1, wr: wr, burst: bst, par_err: pe, addr: a, wdata: d};
    for (n = 0; n < 300; n++) begin
      #400 lnk.clk = 1'b1;
      if (rsp_valid === 1'b1) break;
      #400 lnk.clk = 1'b0;
    end
    r = rsp;
    q = rdata;
    #400 lnk.clk = 1'b0;
    lnk.req = 1'b0;
    // Released lines show the inverse
    lnk.addr = ~a;
    lnk.wdata = ~d;
    #400 lnk.clk = 1'b1;
    #400 lnk.clk = 1'b0;
    for (n = 0; n < 50 && rsp_valid !== 1'b0; n++) #100;
  endtask
endmodule

// ===== testbench/ptra_target_tb_top.sv
module ptra_target_tb_top
  import ptra_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic          wr, bst, pe;
    logic [AW-1:0] a;
    logic [4:0]    free;
    ptra_rsp_e     rsp;
    logic          rdv;
    logic [1:0]    nwr;
  } ptra_row_s;

  localparam ptra_row_s ROWS [12] = '{
    '{1'b0, 1'b1, 1'b0, 20'h00010, 5'h00, RSP_DONE, 1'b1, 2'h0},
    '{1'b1, 1'b1, 1'b0, 20'h00020, 5'h00, RSP_DONE, 1'b0, 2'h1},
    '{1'b0, 1'b0, 1'b0, 20'h00800, 5'h1F, RSP_DONE, 1'b0, 2'h0},
    '{1'b0, 1'b1, 1'b0, 20'h10004, 5'h1F, RSP_DONE, 1'b1, 2'h0},
    '{1'b1, 1'b1, 1'b0, 20'h10008, 5'h1F, RSP_DONE, 1'b0, 2'h1},
    '{1'b0, 1'b0, 1'b1, 20'h20000, 5'h1F, RSP_ABORT, 1'b0, 2'h0},
    '{1'b0, 1'b0, 1'b1, 20'h40000, 5'h1F, RSP_ABORT, 1'b0, 2'h0},
    '{1'b1, 1'b0, 1'b1, 20'h20004, 5'h1F, RSP_DONE, 1'b0, 2'h0},
    '{1'b1, 1'b1, 1'b0, 20'h2000C, 5'h1F, RSP_DISC, 1'b0, 2'h1},
    '{1'b0, 1'b1, 1'b0, 20'h30010, 5'h1F, RSP_DISC, 1'b1, 2'h0},
    '{1'b0, 1'b0, 1'b0, 20'h20014, 5'h1F, RSP_DONE, 1'b1, 2'h0},
    '{1'b0, 1'b0, 1'b0, 20'h50000, 5'h1F, RSP_DONE, 1'b0, 2'h0}};

  logic            clk_sys = 1'b0;
  logic            reset = 1'b1;
  logic [3:0]      avs_address = 4'h0;
  logic            avs_read = 1'b0;
  logic            avs_write = 1'b0;
  logic [31:0]     avs_writedata = 32'h0;
  logic [31:0]     avs_readdata;
  logic            avs_waitrequest, lnk_rsp_valid, app_valid, app_we;
  logic [4:0]      app_free = 5'h1F;
  logic            app_rvalid = 1'b0;
  logic [DW-1:0]   app_rdata = '0;
  logic [DW-1:0]   lnk_rdata, app_wdata, rd;
  logic [DW-1:0]   last_wd = '0;
  logic [AW-1:0]   app_addr, base;
  logic [4:0]      fb;
  ptra_lnk_s       lnk_in;
  ptra_rsp_e       lnk_rsp, rsp;
  ptra_rgn_e       app_rgn;
  int              err_total = 0, compares = 0, wr_cnt = 0, cyc = 0, w0, b;

  initial forever #50 clk_sys = ~clk_sys;

  ptra_target i_dut (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .lnk_in(lnk_in), .lnk_rsp_valid(lnk_rsp_valid), .lnk_rsp(lnk_rsp),
    .lnk_rdata(lnk_rdata), .app_valid(app_valid), .app_rgn(app_rgn), .app_we(app_we), .app_addr(app_addr),
    .app_wdata(app_wdata), .app_free(app_free), .app_rvalid(app_rvalid), .app_rdata(app_rdata));

  ptra_ini_model i_ini (.lnk(lnk_in), .rsp_valid(lnk_rsp_valid), .rsp(lnk_rsp), .rdata(lnk_rdata));

  // **********
  // Memory side and helpers
  // **********
  function automatic logic [DW-1:0] mem_val(input logic [AW-1:0] a);
    return {12'hC3A, a};
  endfunction

  always @(posedge clk_sys) begin
    app_rvalid <= 1'b0;
    app_rdata <= ~app_rdata;
    if (app_valid === 1'b1 && (app_free[app_rgn] === 1'b1 || app_rgn === RGN_REG)) begin
      if (app_we === 1'b1) begin
        wr_cnt <= wr_cnt + 1;
        last_wd <= app_wdata;
      end else begin
        app_rvalid <= 1'b1;
        app_rdata <= mem_val(app_addr);
      end
    end
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      end_sim();
    end
  end

  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic end_sim();
    if (err_total == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    avs_read <= ~w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    av(1'b0, a, 32'h0, q);
    check(nm, q, e);
  endtask

  task automatic lk(input logic w, input logic [AW-1:0] a, input ptra_rsp_e e, input logic [DW-1:0] ed);
    i_ini.phase(w, 1'b0, 1'b0, a, 32'hD000_0000 | a, rsp, rd);
    check("rsp", rsp, e);
    check("rdata", rd, ed);
  endtask

  task automatic setf(input logic [4:0] f);
    @(posedge clk_sys);
    app_free <= f;
  endtask

  // **********
  // Main sequence
  // **********
  initial begin
    @(negedge clk_sys);
    check("rsp_valid", lnk_rsp_valid, 1'b0);
    check("app_valid", app_valid, 1'b0);
    @(posedge clk_sys);
    reset <= 1'b0;
    av(1'b1, 4'hC, 32'hFF, rd);
    av(1'b1, AV_PEND, 32'h7, rd);
    rchk("pend", AV_PEND, 32'h0);
    rchk("err", AV_ERR, 32'h0);
    rchk("mbwait", AV_MBWAIT, MBWAIT_RST);
    rchk("unmapped", 4'hC, 32'h0);
    foreach (ROWS[i]) begin
      setf(ROWS[i].free);
      w0 = wr_cnt;
      i_ini.phase(ROWS[i].wr, ROWS[i].bst, ROWS[i].pe, ROWS[i].a, 32'h1200 + i, rsp, rd);
      check("rsp", rsp, ROWS[i].rsp);
      check("rdata", rd, ROWS[i].rdv ? mem_val(ROWS[i].a) : 32'h0);
      check("writes", wr_cnt - w0, ROWS[i].nwr);
    end
    setf(5'h1D);
    fork
      lk(1'b1, 20'h10040, RSP_DONE, 32'h0);
      begin
        repeat (40) @(negedge clk_sys);
        check("stall", lnk_rsp_valid, 1'b0);
        check("stall req", app_valid, 1'b1);
        setf(5'h1F);
      end
    join
    for (int q = 0; q < 2; q++) begin
      b = 1 << q;
      base = (q == 0) ? 20'h20000 : 20'h30000;
      fb = (q == 0) ? 5'h1B : 5'h17;
      setf(fb);
      lk(1'b1, base | 20'h40, RSP_DONE, 32'h0);
      rchk("pend", AV_PEND, b);
      lk(1'b0, base | 20'h44, RSP_RETRY, 32'h0);
      setf(5'h1F);
      repeat (30) @(posedge clk_sys);
      rchk("pend", AV_PEND, 32'h0);
      check("posted", last_wd, 32'hD000_0000 | (base | 20'h40));
      setf(fb);
      w0 = wr_cnt;
      lk(1'b1, base | 20'h48, RSP_DONE, 32'h0);
      lk(1'b1, base | 20'h4C, RSP_DONE, 32'h0);
      rchk("err", AV_ERR, b);
      rchk("pend", AV_PEND, 32'h0);
      setf(5'h1F);
      repeat (30) @(posedge clk_sys);
      check("dropped", wr_cnt - w0, 32'h0);
      av(1'b1, AV_ERR, b, rd);
      setf(fb);
      lk(1'b0, base | 20'h50, RSP_RETRY, 32'h0);
      lk(1'b0, base | 20'h54, RSP_RETRY, 32'h0);
      lk(1'b1, base | 20'h58, RSP_DONE, 32'h0);
      rchk("err", AV_ERR, b);
      av(1'b1, AV_ERR, b, rd);
      lk(1'b0, base | 20'h5C, RSP_RETRY, 32'h0);
      lk(1'b0, base | 20'h5C, RSP_RETRY, 32'h0);
      setf(5'h1F);
      repeat (30) @(posedge clk_sys);
      lk(1'b0, base | 20'h5C, RSP_DONE, mem_val(base | 20'h5C));
      rchk("err", AV_ERR, 32'h0);
    end
    setf(5'h0F);
    lk(1'b1, 20'h40010, RSP_DONE, 32'h0);
    rchk("pend", AV_PEND, 32'h4);
    lk(1'b1, 20'h40014, RSP_DONE, 32'h0);
    rchk("err", AV_ERR, 32'h4);
    rchk("pend", AV_PEND, 32'h4);
    setf(5'h1F);
    repeat (40) @(posedge clk_sys);
    rchk("pend", AV_PEND, 32'h0);
    check("mb data", last_wd, 32'hD004_0010);
    av(1'b1, AV_MBWAIT, 32'h10, rd);
    rchk("mbwait", AV_MBWAIT, 32'h10);
    lk(1'b0, 20'h40020, RSP_RETRY, 32'h0);
    repeat (60) @(posedge clk_sys);
    lk(1'b0, 20'h40020, RSP_DONE, mem_val(20'h40020));
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    @(negedge clk_sys);
    check("rsp_valid rst", lnk_rsp_valid, 1'b0);
    check("app_valid rst", app_valid, 1'b0);
    rchk("err rst", AV_ERR, 32'h0);
    rchk("mbwait rst", AV_MBWAIT, MBWAIT_RST);
    end_sim();
  end
endmodule
